// ### pkg/otm_cfg.svh
`ifndef OTM_CFG_SVH
`define OTM_CFG_SVH
`define OTM_ADDR_MODE_SET    8'h04
`define OTM_ADDR_MODE_CLR    8'h05
`define OTM_ADDR_VER_LO      8'h14
`define OTM_ADDR_VER_HI      8'h15
`define OTM_BIT_UART         6
`define OTM_BIT_OE_INT       5
`define OTM_BIT_AUTO_CONN    4
`define OTM_BIT_GP_BUF       3
`define OTM_BIT_SE_ENC       2
`define OTM_BIT_SUSPEND      1
`define OTM_BIT_SPEED        0
`define OTM_MODE_RST         8'h00
`define OTM_MODE_USED_MASK   8'h7F
`define OTM_VER_PKG_MSB      15
`define OTM_VER_PKG_LSB      12
`define OTM_VER_SCHEME_MSB   11
`define OTM_VER_SCHEME_LSB   8
`define OTM_VER_MAJOR_MSB    7
`define OTM_VER_MAJOR_LSB    4
`define OTM_VER_MINOR_MSB    3
`define OTM_VER_MINOR_LSB    0
`endif

// ### pkg/otm_pkg.sv
package otm_pkg;
  typedef enum logic [1:0]
  {
    OTM_ST_STRAP = 2'b01,
    OTM_ST_RUN   = 2'b10
  } otm_state_t;
endpackage

// ### rtl/otm_mode_regs.sv
`timescale 1ns/1ps
`include "otm_cfg.svh"
module otm_mode_regs #(
  parameter logic [3:0] PKG_CODE   = 4'h0,
  parameter logic [3:0] SCHEME     = 4'h0,
  parameter logic [3:0] MAJOR_REV  = 4'h1,
  parameter logic [3:0] MINOR_REV  = 4'h0
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Register access
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Strap and status
  input  wire logic       service_strap_n,
  input  wire logic       a_device_role,
  input  wire logic       peer_detach_seen,
  input  wire logic       peer_attach_seen,
  input  wire logic       plus_line_pullup_ctl,
  input  wire logic       irq_event,
  // Transceiver controls
  output logic            uart_passthrough,
  output logic            gp_buffer_passthrough_select,
  output logic            single_ended_encoding_select,
  output logic            low_power,
  output logic            full_speed_edges,
  output logic            diff_rx_enable,
  output logic            plus_pullup_on,
  output logic            drive_se0,
  output logic            oe_pin_out,
  output logic            oe_pin_oe
);
  // Refuse version fields the logic cannot report
  if (MAJOR_REV == 4'h0)
  begin
    $error("major revision starts at 1");
  end
  if (PKG_CODE > 4'h1)
  begin
    $error("package code is 0 or 1");
  end

  // Strobe and address match
  function automatic logic otm_addr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] match);
    otm_addr_hit = strobe && (addr == match);
  endfunction

  // Register state
  otm_pkg::otm_state_t state_reg;
  logic [7:0]          mode_reg;
  logic                pullup_latch_reg;
  logic                se0_latch_reg;

  // Decoded strobes
  logic                strap_cycle;
  logic                set_hit;
  logic                clr_hit;
  logic                mode_rd_hit;
  logic [7:0]          set_value;
  logic [7:0]          clr_value;
  logic [15:0]         version_identifier;

  assign strap_cycle = (state_reg == otm_pkg::OTM_ST_STRAP);
  assign set_hit     = otm_addr_hit(reg_wr, reg_addr, `OTM_ADDR_MODE_SET);
  assign clr_hit     = otm_addr_hit(reg_wr, reg_addr, `OTM_ADDR_MODE_CLR);
  assign mode_rd_hit = otm_addr_hit(reg_rd, reg_addr, `OTM_ADDR_MODE_SET) ||
                       otm_addr_hit(reg_rd, reg_addr, `OTM_ADDR_MODE_CLR);
  assign set_value   = (mode_reg | reg_wdata) & `OTM_MODE_USED_MASK;
  assign clr_value   = mode_reg & ~reg_wdata;

  // Version word from fixed fields
  assign version_identifier[`OTM_VER_PKG_MSB:`OTM_VER_PKG_LSB]       = PKG_CODE;
  assign version_identifier[`OTM_VER_SCHEME_MSB:`OTM_VER_SCHEME_LSB] = SCHEME;
  assign version_identifier[`OTM_VER_MAJOR_MSB:`OTM_VER_MAJOR_LSB]   = MAJOR_REV;
  assign version_identifier[`OTM_VER_MINOR_MSB:`OTM_VER_MINOR_LSB]   = MINOR_REV;

  // Strap capture after reset release
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state_reg <= otm_pkg::OTM_ST_STRAP;
    else
    begin
      case (state_reg)
        otm_pkg::OTM_ST_STRAP: state_reg <= otm_pkg::OTM_ST_RUN;
        otm_pkg::OTM_ST_RUN:   state_reg <= otm_pkg::OTM_ST_RUN;
        default:               state_reg <= otm_pkg::OTM_ST_STRAP;
      endcase
    end
  end

  // Mode register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      mode_reg <= `OTM_MODE_RST;
    else if (strap_cycle)
      mode_reg[`OTM_BIT_UART] <= ~service_strap_n;
    else if (set_hit)
      mode_reg <= set_value;
    else if (clr_hit)
      mode_reg <= clr_value;
  end

  // Read data
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (mode_rd_hit)
      reg_rdata <= mode_reg;
    else if (reg_rd)
    begin
      case (reg_addr)
        `OTM_ADDR_VER_LO: reg_rdata <= version_identifier[7:0];
        `OTM_ADDR_VER_HI: reg_rdata <= version_identifier[15:8];
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // Pull-up latch on peer detach, A role
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pullup_latch_reg <= 1'b0;
    else if (!mode_reg[`OTM_BIT_AUTO_CONN] || !a_device_role)
      pullup_latch_reg <= 1'b0;
    else if (peer_detach_seen)
      pullup_latch_reg <= 1'b1;
  end

  // SE0 latch on peer attach, B role
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      se0_latch_reg <= 1'b0;
    else if (!mode_reg[`OTM_BIT_AUTO_CONN] || a_device_role)
      se0_latch_reg <= 1'b0;
    else if (peer_attach_seen)
      se0_latch_reg <= 1'b1;
  end

  // Mode bit copies
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      uart_passthrough             <= 1'b0;
      gp_buffer_passthrough_select <= 1'b0;
      single_ended_encoding_select <= 1'b0;
      low_power                    <= 1'b0;
      full_speed_edges             <= 1'b0;
    end
    else
    begin
      uart_passthrough             <= mode_reg[`OTM_BIT_UART];
      gp_buffer_passthrough_select <= mode_reg[`OTM_BIT_GP_BUF];
      single_ended_encoding_select <= mode_reg[`OTM_BIT_SE_ENC];
      low_power                    <= mode_reg[`OTM_BIT_SUSPEND];
      full_speed_edges             <= mode_reg[`OTM_BIT_SPEED];
    end
  end

  // Differential receiver enable
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      diff_rx_enable <= 1'b1;
    else
      diff_rx_enable <= ~(mode_reg[`OTM_BIT_SUSPEND] & mode_reg[`OTM_BIT_SPEED]);
  end

  // Plus line pull-up
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      plus_pullup_on <= 1'b0;
    else if (!a_device_role)
      plus_pullup_on <= 1'b0;
    else if (mode_reg[`OTM_BIT_AUTO_CONN])
      plus_pullup_on <= pullup_latch_reg;
    else
      plus_pullup_on <= plus_line_pullup_ctl;
  end

  // SE0 drive
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      drive_se0 <= 1'b0;
    else
      drive_se0 <= se0_latch_reg;
  end

  // Shared enable pin, driven only in suspend
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      oe_pin_oe  <= 1'b0;
      oe_pin_out <= 1'b1;
    end
    else
    begin
      oe_pin_oe  <= mode_reg[`OTM_BIT_OE_INT] & mode_reg[`OTM_BIT_SUSPEND];
      oe_pin_out <= ~irq_event;
    end
  end
endmodule

// ### testbench/otm_host_model.sv
`timescale 1ns/1ps
module otm_host_model (
  // Clock
  input wire logic   clk_sys,
  // Register access
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys);
    {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys);
    reg_rd = 0;
  endtask
endmodule

// ### testbench/otm_properties.sv
`timescale 1ns/1ps
module otm_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // Watched ports
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_event,
  input wire logic       low_power,
  input wire logic       full_speed_edges,
  input wire logic       diff_rx_enable,
  input wire logic       oe_pin_out,
  input wire logic       oe_pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_ver_low: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata == 8'h10) else $error("ver lo");
  a_ver_high: assert property (reg_rd && reg_addr == 8'h15 |=> reg_rdata == 8'h00) else $error("ver hi");
  a_mode_bit7: assert property (reg_rd && reg_addr == 8'h04 |=> !reg_rdata[7]) else $error("bit7");
  a_set_speed: assert property (reg_wr && reg_addr == 8'h04 && reg_wdata[0] |-> ##2 full_speed_edges) else $error("set");
  a_clr_speed: assert property (reg_wr && reg_addr == 8'h05 && reg_wdata[0] |-> ##2 !full_speed_edges) else $error("clr");
  a_rx_off: assert property (diff_rx_enable == !(low_power && full_speed_edges)) else $error("rx");
  a_oe_drive: assert property (oe_pin_oe |-> low_power) else $error("oe");
  a_oe_level: assert property ($past(irq_event) && !$past(sys_rst) |-> !oe_pin_out) else $error("irq");
  a_oe_idle: assert property (!$past(irq_event) && !$past(sys_rst) |-> oe_pin_out) else $error("idle");
endmodule
bind otm_mode_regs otm_checker otm_checker_inst (.*);

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] a, d, e;} otm_row_t;
  logic clk_sys = 0, sys_rst = 1, service_strap_n = 1, a_device_role = 0, irq_event = 0;
  logic peer_detach_seen = 0, peer_attach_seen = 0, plus_line_pullup_ctl = 0;
  logic reg_wr, reg_rd, uart_passthrough, gp_buffer_passthrough_select, single_ended_encoding_select;
  logic low_power, full_speed_edges, diff_rx_enable, plus_pullup_on, drive_se0, oe_pin_out, oe_pin_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int errors = 0, n_checks = 0, cyc = 0;
  otm_row_t rows [5] = '{'{8'h04, 8'hFF, 8'h7F}, '{8'h05, 8'h0A, 8'h75}, '{8'h05, 8'h41, 8'h34},
                         '{8'h14, 8'hFF, 8'h34}, '{8'h04, 8'h03, 8'h37}};
  always #5 clk_sys = ~clk_sys;
  otm_mode_regs otm_mode_regs_inst (.*);
  otm_host_model otm_host_model_inst (.*);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    otm_host_model_inst.rd(a);
    chk(reg_rdata, e);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
    if (++cyc == 500)
    begin
      errors++;
      wrap_up;
    end
  initial
  begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 0;
    repeat (2) @(negedge clk_sys);
    rd_chk(8'h04, 8'h00);
    foreach (rows[i])
    begin
      otm_host_model_inst.wr(rows[i].a, rows[i].d);
      rd_chk(8'h04, rows[i].e);
    end
    chk({uart_passthrough, gp_buffer_passthrough_select, single_ended_encoding_select, low_power,
         full_speed_edges, diff_rx_enable, oe_pin_oe, 1'b0}, 8'h3A);
    irq_event = 1;
    repeat (2) @(negedge clk_sys);
    chk(oe_pin_out, 0);
    irq_event = 0;
    repeat (2) @(negedge clk_sys);
    chk(oe_pin_out, 1);
    $display("rows done");
    a_device_role = 1;
    peer_detach_seen = 1;
    @(negedge clk_sys);
    peer_detach_seen = 0;
    repeat (2) @(negedge clk_sys);
    chk(plus_pullup_on, 1);
    otm_host_model_inst.wr(8'h05, 8'h10);
    repeat (2) @(negedge clk_sys);
    chk(plus_pullup_on, 0);
    plus_line_pullup_ctl = 1;
    repeat (2) @(negedge clk_sys);
    chk(plus_pullup_on, 1);
    plus_line_pullup_ctl = 0;
    a_device_role = 0;
    otm_host_model_inst.wr(8'h04, 8'h10);
    peer_attach_seen = 1;
    @(negedge clk_sys);
    peer_attach_seen = 0;
    repeat (2) @(negedge clk_sys);
    chk(drive_se0, 1);
    otm_host_model_inst.wr(8'h05, 8'h10);
    repeat (2) @(negedge clk_sys);
    chk(drive_se0, 0);
    $display("link done");
    {service_strap_n, sys_rst} = 2'b01;
    repeat (4) @(negedge clk_sys);
    sys_rst = 0;
    repeat (2) @(negedge clk_sys);
    rd_chk(8'h04, 8'h40);
    chk(uart_passthrough, 1);
    rd_chk(8'h15, 8'h00);
    rd_chk(8'h14, 8'h10);
    rd_chk(8'h20, 8'h00);
    $display("reset done");
    wrap_up;
  end
endmodule
